// ==== rtl/sap_pkg.sv ====
// Shared constants for the parallel host port of the sampling converter
package sap_pkg;

    // Widths of the result and the parallel bus
    localparam int unsigned RES_W             = 12;  // Result width
    localparam int unsigned BYTE_W            = 8;   // Width of one byte read
    localparam int unsigned PAD_W             = 4;   // Padding lines, always low when driven
    localparam int unsigned RESULT_BIT_TOP    = 11;  // Result MSB lane
    localparam int unsigned RESULT_BIT_BOTTOM = 0;   // Result LSB lane

    // Clock and conversion timing
    localparam int unsigned CLK_PERIOD_NS     = 10;  // Core clock period
    localparam int unsigned STEP_TIME_NS      = 660; // Least time of one approximation step
    localparam int unsigned SAP_STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset values
    localparam logic        BUSY_N_RST        = 1'h1;      // Not busy after power-up
    localparam logic [2:0]  PIN_SYNC_RST      = 3'h3;      // {byte, rd_conv, cs_n}: idle levels
    localparam logic [11:0] RESULT_RST        = 12'h000;   // Midscale until first conversion
    localparam logic [3:0]  PAD_VALUE         = 4'h0;      // Padding lines drive low

    // Sample to two's complement: flip the sign bit of an offset-binary code
    localparam logic [11:0] TWOS_FLIP         = 12'h800;

endpackage

// ==== rtl/sap_conv_if.sv ====
// Start/result handshake between the host port and the approximation core
`timescale 1ns/1ps
interface sap_conv_if;
    import sap_pkg::*;

    logic             start;   // One-cycle conversion start
    logic [RES_W-1:0] sample;  // Offset-binary input level
    logic             idle;    // Core ready for a start
    logic             done;    // One-cycle result strobe
    logic [RES_W-1:0] result;  // Two's complement result

    modport ctrl (output start, output sample, input idle, input done, input result);
    modport core (input start, input sample, output idle, output done, output result);
endinterface

// ==== rtl/sap_sar_core.sv ====
// Successive approximation sequencer producing a two's complement code
`timescale 1ns/1ps
module sap_sar_core
    import sap_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = SAP_STEP_CYCLES  // Cycles per bit decision
) (
    input  wire logic  clk_i,    // Core clock
    input  wire logic  rst_n_i,  // Asynchronous reset, active low
    sap_conv_if.core   conv      // Start and result handshake
);

    // Refuse a step length the counter cannot serve
    if (STEP_CYCLES < 1 || STEP_CYCLES > 4096) begin : g_bad_step
        $error("STEP_CYCLES out of range");
    end

    localparam int unsigned CNT_W = $clog2(STEP_CYCLES + 1);
    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

    typedef enum logic [2:0] {
        SC_IDLE = 3'b001,
        SC_CONV = 3'b010,
        SC_DONE = 3'b100
    } sap_core_st_t;

    sap_core_st_t     state_r;  // Sequencer state
    logic [RES_W-1:0] hold_r;   // Held sample during conversion
    logic [RES_W-1:0] sar_r;    // Approximation register
    logic [RES_W-1:0] trial;    // Current bit under test set
    logic [RES_W-1:0] mask_r;   // One-hot bit under test
    logic [CNT_W-1:0] cnt_r;    // Cycles within a step

    assign trial       = sar_r | mask_r;
    assign conv.idle   = (state_r == SC_IDLE);
    assign conv.done   = (state_r == SC_DONE);
    assign conv.result = sar_r ^ TWOS_FLIP;

    // Sequencer: hold, then one decision per step, MSB first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= SC_IDLE;
            hold_r  <= '0;
            sar_r   <= '0;
            mask_r  <= '0;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                SC_IDLE: begin
                    // Sample is frozen here; later input changes are not seen
                    if (conv.start) begin
                        hold_r  <= conv.sample;
                        sar_r   <= '0;
                        mask_r  <= TWOS_FLIP;
                        cnt_r   <= '0;
                        state_r <= SC_CONV;
                    end
                end
                SC_CONV: begin
                    // Start requests are not looked at while converting
                    if (cnt_r == STEP_LAST) begin
                        cnt_r <= '0;
                        if (trial <= hold_r) begin
                            sar_r <= trial;
                        end
                        mask_r <= mask_r >> 1;
                        if (mask_r[0]) begin
                            state_r <= SC_DONE;
                        end
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                SC_DONE: begin
                    state_r <= SC_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_code_full_pos: assert property (conv.done && hold_r == 12'hFFF |-> conv.result == 12'h7FF)
        else $error("full positive code wrong");
    a_code_midscale: assert property (conv.done && hold_r == 12'h800 |-> conv.result == 12'h000)
        else $error("midscale code wrong");
    a_code_full_neg: assert property (conv.done && hold_r == 12'h000 |-> conv.result == 12'h800)
        else $error("full negative code wrong");

endmodule

// ==== rtl/sap_host_port.sv ====
// Parallel host port: chip select, read/convert, byte select, busy, data bus
`timescale 1ns/1ps
module sap_host_port
    import sap_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = SAP_STEP_CYCLES  // Cycles per bit decision
) (
    input  wire logic              CORE_CLK_I,      // Core clock, 100 MHz
    input  wire logic              RESET_N_I,       // Asynchronous reset, active low
    input  wire logic              CS_N_I,          // Chip select pin, active low
    input  wire logic              RD_CONV_I,       // Read (high) / convert (low) pin
    input  wire logic              BYTE_SEL_I,      // Byte select pin
    input  wire logic [RES_W-1:0]  SAMPLE_I,        // Offset-binary front-end level
    output logic      [RES_W-1:0]  DATA_O,          // Result bus value
    output logic      [RES_W-1:0]  DATA_OE_O,       // Result bus drive enable
    output logic      [PAD_W-1:0]  PAD_LOW_LINE_O,  // Padding line value
    output logic      [PAD_W-1:0]  PAD_OE_O,        // Padding line drive enable
    output logic                   BUSY_N_O         // Busy, active low
);

    // Refuse settings the core cannot serve
    if (STEP_CYCLES < 1 || STEP_CYCLES > 4096) begin : g_bad_step
        $error("STEP_CYCLES out of range");
    end

    // Pin synchronisers, bit order {byte, rd_conv, cs_n}
    logic [2:0]       pin_meta_r;   // First stage, read only by second
    logic [2:0]       pin_sync_r;   // Second stage, safe to use
    logic             cs_n_s;       // Synchronised chip select
    logic             rd_conv_s;    // Synchronised read/convert
    logic             byte_s;       // Synchronised byte select

    // Conversion control
    logic             req_hi;       // OR of select and read/convert
    logic             req_hi_d_r;   // Previous value of req_hi
    logic             rearm_r;      // Busy just rose; level still counts
    logic             start_go;     // Conversion start this cycle
    logic             upd_r;        // Result register just loaded

    // Result path
    logic [RES_W-1:0] result_r;     // Last finished result
    logic             drive_req;    // Host is reading
    logic [RES_W-1:0] bus_word;     // Byte-routed result

    // Check helper: busy-low span of one conversion, store and release included
    localparam int unsigned BUSY_SPAN = RES_W * STEP_CYCLES + 2;
    logic [15:0]      busy_cnt_r;   // Busy-low cycles so far

    sap_conv_if conv ();

    // Two flops on each of the three control pins
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pin_meta_r <= PIN_SYNC_RST;
            pin_sync_r <= PIN_SYNC_RST;
        end else begin
            pin_meta_r <= {BYTE_SEL_I, RD_CONV_I, CS_N_I};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign cs_n_s    = pin_sync_r[0];
    assign rd_conv_s = pin_sync_r[1];
    assign byte_s    = pin_sync_r[2];

    // Select and read/convert act as one active-low request line
    assign req_hi = cs_n_s | rd_conv_s;

    // Start on the falling request while idle, or on a request still low
    // when busy rises, since the inputs are level triggered
    assign start_go = BUSY_N_O && !req_hi && (req_hi_d_r || rearm_r) && conv.idle;

    assign conv.start  = start_go;
    assign conv.sample = SAMPLE_I;

    // Request edge history
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            req_hi_d_r <= 1'b1;
        end else begin
            req_hi_d_r <= req_hi;
        end
    end

    sap_sar_core #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_core (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RESET_N_I),
        .conv    (conv.core)
    );

    // Result register keeps conversion n-1 readable during conversion n
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            result_r <= RESULT_RST;
            upd_r    <= 1'b0;
        end else begin
            upd_r <= conv.done;
            if (conv.done) begin
                result_r <= conv.result;
            end
        end
    end

    // Busy falls on start, rises one cycle after the result is stored
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            BUSY_N_O <= BUSY_N_RST;
            rearm_r  <= 1'b0;
        end else begin
            rearm_r <= upd_r;
            if (start_go) begin
                BUSY_N_O <= 1'b0;
            end else if (upd_r) begin
                BUSY_N_O <= 1'b1;
            end
        end
    end

    // Bus enabled only with select low and read/convert high
    assign drive_req = !cs_n_s && rd_conv_s;

    // Byte routing: low selects top byte on the upper lanes, high the low byte
    always_comb begin
        if (byte_s) begin
            bus_word = {result_r[BYTE_W-1:0], result_r[RESULT_BIT_TOP -: (RES_W - BYTE_W)]};
        end else begin
            bus_word = result_r;
        end
    end

    // Registered bus drive; enables clear at reset so the pins float
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            DATA_O         <= RESULT_RST;
            DATA_OE_O      <= '0;
            PAD_LOW_LINE_O <= PAD_VALUE;
            PAD_OE_O       <= '0;
        end else begin
            DATA_O         <= bus_word;
            DATA_OE_O      <= {RES_W{drive_req}};
            PAD_LOW_LINE_O <= PAD_VALUE;
            PAD_OE_O       <= {PAD_W{drive_req}};
        end
    end

    // Busy-low cycle count, read only by the checks below; it cannot
    // wrap because step lengths above 4096 are refused
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            busy_cnt_r <= 16'h0000;
        end else if (BUSY_N_O) begin
            busy_cnt_r <= 16'h0000;
        end else begin
            busy_cnt_r <= busy_cnt_r + 16'h0001;
        end
    end

    // Checks on the port behaviour
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    // Idle request line, then its fall while not busy
    sequence s_req_fall;
        req_hi ##1 !req_hi && BUSY_N_O && conv.idle;
    endsequence

    // Result strobe, then a finished result loaded
    sequence s_result_loaded;
        conv.done ##1 upd_r;
    endsequence

    // Read/convert already low, then select falls while not busy
    sequence s_sel_fall;
        cs_n_s && !rd_conv_s ##1 !cs_n_s && !rd_conv_s && BUSY_N_O && conv.idle;
    endsequence

    a_msb_lane_top: assert property ($past(!byte_s) |-> DATA_O[RESULT_BIT_TOP] == $past(result_r[11]))
        else $error("MSB not on bit 11");
    a_lsb_lane_bottom: assert property ($past(!byte_s) |-> DATA_O[RESULT_BIT_BOTTOM] == $past(result_r[0]))
        else $error("LSB not on bit 0");
    a_data_hiz: assert property (!drive_req |=> DATA_OE_O == 12'h000)
        else $error("data driven outside a read");
    a_pad_drive: assert property (##1 PAD_OE_O == {4{$past(drive_req)}} && PAD_LOW_LINE_O == 4'h0)
        else $error("padding lines wrong");
    a_byte_high_lanes: assert property (byte_s |=> DATA_O[11:4] == $past(result_r[7:0]))
        else $error("low byte not routed");
    a_conv_start: assert property (s_req_fall |=> !BUSY_N_O)
        else $error("falling request did not start");
    a_read_enable: assert property ($rose(rd_conv_s) && !cs_n_s |=> DATA_OE_O == 12'hFFF)
        else $error("read edge did not enable bus");
    a_busy_until_load: assert property ($rose(BUSY_N_O) |-> $past(upd_r) && $past(result_r, 1) == result_r)
        else $error("busy rose before result stored");
    a_busy_covers_load: assert property (s_result_loaded |-> !BUSY_N_O ##1 BUSY_N_O)
        else $error("busy not released after load");
    a_ignore_busy: assert property (!BUSY_N_O |-> !start_go ##1 !conv.idle || upd_r || BUSY_N_O)
        else $error("request honoured while busy");
    a_select_start: assert property (s_sel_fall |=> !BUSY_N_O)
        else $error("falling select did not start");
    a_start_takes: assert property (start_go |=> !BUSY_N_O && !conv.idle)
        else $error("start did not enter conversion");
    a_busy_bound: assert property (!BUSY_N_O |-> busy_cnt_r < 16'(BUSY_SPAN))
        else $error("busy held too long");
    a_busy_span_exact: assert property ($rose(BUSY_N_O) |-> $past(busy_cnt_r) == 16'(BUSY_SPAN - 1))
        else $error("busy span length wrong");
    a_old_result_held: assert property (!BUSY_N_O && !conv.done |=> $stable(result_r))
        else $error("result changed mid conversion");

endmodule

// ==== dv/sap_ctrl_model.sv ====
// Behavioural host controller that drives the convert, select and byte strobes
`timescale 1ns/1ps
module sap_ctrl_model (
    input  wire logic clk_i,      // Core clock
    output logic      cs_n_o,     // Chip select, active low
    output logic      rd_conv_o,  // Read (high) / convert (low)
    output logic      byte_sel_o  // Byte select
);
    localparam int unsigned DLY  = 1;  // Drive delay after the edge
    localparam int unsigned HOLD = 4;  // Request low time, 40 ns at 100 MHz

    // Idle levels: nothing selected, read level
    initial begin
        cs_n_o     = 1'b1;
        rd_conv_o  = 1'b1;
        byte_sel_o = 1'b0;
    end

    // Wait n edges, then move just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #DLY;
    endtask

    // Select first, so a short read of the old result precedes the start
    task automatic conv_rc();
        byte_sel_o = 1'b0;
        cs_n_o     = 1'b0;
        step(4);
        rd_conv_o = 1'b0;
        step(HOLD);
        cs_n_o    = 1'b1;
        rd_conv_o = 1'b1;
        step(1);
    endtask

    // Convert level first, select falls last and starts the conversion
    task automatic conv_cs();
        rd_conv_o = 1'b0;
        step(2);
        cs_n_o = 1'b0;
        step(HOLD);
        cs_n_o    = 1'b1;
        rd_conv_o = 1'b1;
        step(1);
    endtask

    // Both lines low together: a convert request with no read phase
    task automatic poke();
        cs_n_o    = 1'b0;
        rd_conv_o = 1'b0;
        step(HOLD);
        cs_n_o    = 1'b1;
        rd_conv_o = 1'b1;
        step(1);
    endtask

    // One read of the chosen byte, then the bus is given back
    task automatic read(input logic b);
        byte_sel_o = b;
        cs_n_o     = 1'b0;
        step(6);
        cs_n_o = 1'b1;
        step(4);  // Enables must be gone before the next access
    endtask
endmodule

// ==== dv/tb_sar_adc_parallel_host_port.sv ====
// Self-checking bench for the parallel host port of the sampling converter
`timescale 1ns/1ps
module tb_sar_adc_parallel_host_port;
    import sap_pkg::*;
    localparam int unsigned STP = 1;  // Short steps keep the run brief
    logic             clk = 1'b0;     // Core clock
    logic             rst_n = 1'b0;   // Reset, active low
    logic             cs_n, rd_conv, byte_sel;
    logic [RES_W-1:0] sample = '0;    // Front-end level
    logic [RES_W-1:0] data, data_oe;
    logic [PAD_W-1:0] pad, pad_oe;
    logic             busy_n;
    logic [RES_W-1:0] q_data[$];      // Expected bus values, oldest first
    int               q_busy[$];      // Expected busy-low lengths
    int               error_cnt = 0;
    int               n_checks = 0;
    logic [31:0]      rnd = 32'h33;   // Xorshift state, seed 51

    always #5 clk = ~clk;

    sap_host_port #(.STEP_CYCLES(STP)) DUT (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .CS_N_I(cs_n), .RD_CONV_I(rd_conv),
        .BYTE_SEL_I(byte_sel), .SAMPLE_I(sample), .DATA_O(data), .DATA_OE_O(data_oe),
        .PAD_LOW_LINE_O(pad), .PAD_OE_O(pad_oe), .BUSY_N_O(busy_n));

    sap_ctrl_model u_ctl (.clk_i(clk), .cs_n_o(cs_n), .rd_conv_o(rd_conv), .byte_sel_o(byte_sel));

    // Compare and count
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Single place where the run ends
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Bus enable seen: compare the driven word with the oldest note
    always @(posedge data_oe[0]) begin
        #1;
        check("oe", data_oe, 12'hFFF);
        check("pad_oe", {8'h00, pad_oe}, 12'h00F);
        check("pad", {8'h00, pad}, 12'h000);
        check("data", data, q_data.pop_front());
    end

    // Bus released: padding lines let go as well
    always @(negedge data_oe[0]) begin
        #1;
        check("oe_off", data_oe, 12'h000);
        check("pad_off", {8'h00, pad_oe}, 12'h000);
    end

    // Busy low: bus quiet, and the low span has the expected length
    always @(negedge busy_n) begin
        int n;
        n = 0;
        #1;
        check("oe_conv", data_oe, 12'h000);
        while (busy_n === 1'b0 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("busy_len", 12'(n), 12'(q_busy.pop_front()));
    end

    // Hang guard
    initial begin
        #50000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        logic [11:0] tbl[4];
        logic [11:0] last, exp;
        int          n;
        tbl  = '{12'hFFF, 12'h000, 12'h7FF, 12'h800};
        last = RESULT_RST;
        repeat (4) @(posedge clk);
        check("busy_rst", {11'h0, busy_n}, 12'h001);
        check("oe_rst", data_oe, 12'h000);
        #1 rst_n = 1'b1;
        u_ctl.step(3);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            sample = (i < 4) ? tbl[i] : rnd[11:0];
            exp = sample ^ TWOS_FLIP;
            // Busy stays low for twelve steps, one cycle to store, one to release
            q_busy.push_back(12 * STP + 2);
            if (i % 2 == 0) begin
                q_data.push_back(last);
                u_ctl.conv_rc();
            end else begin
                u_ctl.conv_cs();
            end
            if (i == 2) begin
                u_ctl.poke();
            end
            n = 0;
            while (busy_n !== 1'b1 && n < 100) begin
                u_ctl.step(1);
                n++;
            end
            check("ready", 12'(n < 100), 12'h001);
            u_ctl.step(2);
            last = exp;
            q_data.push_back(exp);
            u_ctl.read(1'b0);
            q_data.push_back({exp[7:0], exp[11:8]});
            u_ctl.read(1'b1);
        end
        check("left_data", 12'(q_data.size()), 12'h000);
        check("left_busy", 12'(q_busy.size()), 12'h000);
        end_of_test();
    end
endmodule
